// >>> src/adcseq_pkg.sv
// Constants and carrier types for the conversion sequencer
package adcseq_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int DIV_CNT_W = 7;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_C = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_RES_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RES_LO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ = 3'h5;

  // Field positions
  localparam int CA_START = 7;
  localparam int CA_BUSY = 6;
  localparam int CA_POWER = 5;
  localparam int CA_ALIGN = 4;
  localparam int CB_DIV_LSB = 0;
  localparam int CB_REF_LSB = 4;
  localparam int CC_CHAN_LSB = 0;
  localparam int CC_SRC_LSB = 5;
  localparam int IRQ_GIE = 0;
  localparam int IRQ_CIE = 1;
  localparam int IRQ_FLAG = 2;

  // Reset values
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [1:0] RST_REF = 2'h0;
  localparam logic [2:0] RST_SRC = 3'h0;
  localparam logic [4:0] RST_CHAN = 5'h00;
  localparam logic [RES_W-1:0] RST_RESULT = 12'h000;

  // Selection encodings
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_EXT_ALT_MIN = 3'h5;
  localparam logic [4:0] CHAN_NONE_MIN = 5'h18;

  // Conversion timing in converter clock periods
  localparam logic [3:0] SAMPLE_CLKS = 4'h4;
  localparam logic [3:0] CONV_CLKS = 4'hC;
  localparam logic [4:0] TOTAL_CLKS = 5'h10;

  // Code scale
  localparam logic [RES_W-1:0] FULL_SCALE = 12'h0FFF;
  localparam logic [RES_W-1:0] SAR_MSB = 12'h0800;
  localparam int CODE_STEPS = 4096;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } adcseq_bus_req_t;

  typedef struct packed {
    logic power_en;
    logic sample_en;
    logic ref_from_supply;
    logic bandgap_sel;
    logic ext_channel_en;
    logic [4:0] channel_sel;
    logic [2:0] internal_source_sel;
    logic [RES_W-1:0] dac_code;
  } adcseq_analog_t;

endpackage : adcseq_pkg

// >>> src/adcseq_clkdiv.sv
// Converter clock divider producing one tick per converter clock period
`timescale 1ns/1ps
module adcseq_clkdiv (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic [2:0] conv_clock_div_sel,
  output logic tick
);
  import adcseq_pkg::*;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic tick;
  } adcseq_div_state_t;

  adcseq_div_state_t s;
  adcseq_div_state_t next_s;
  logic [DIV_CNT_W-1:0] term;

  // Period is two to the power of the select field
  always_comb begin
    next_s = s;
    term = DIV_CNT_W'((8'h01 << conv_clock_div_sel) - 8'h01);
    if (clear) begin
      next_s.cnt = '0;
      next_s.tick = 1'b0;
    end else if (s.cnt == term) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = DIV_CNT_W'(s.cnt + 7'h01);
      next_s.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : adcseq_clkdiv

// >>> src/adcseq_top.sv
// Conversion sequencer for a 12-bit successive-approximation converter
// Summary of operation
// - Sample four periods, then twelve approximation periods
// - Conversion runs on its own once started
// - Converter runs only while power enable set
// - Power enable low powers analog circuits down
// - Align bit places result in two bytes
// - Start high holds reset; low begins conversion
// - Busy flag high throughout conversion
// - Completion clears busy, result bytes valid
// - Unsigned code, full scale 0FFF equals reference
// - One step is reference over 4096
// - Reference from supply only for select 01
// - Source 001 with unused channel picks bandgap
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module adcseq_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire adcseq_pkg::adcseq_bus_req_t bus,
  output logic [adcseq_pkg::DATA_W-1:0] rdata,
  input wire logic cmp_above,
  output adcseq_pkg::adcseq_analog_t analog,
  output logic conv_busy_flag,
  output logic conv_irq_req
);
  import adcseq_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_SAMPLE, ST_CONVERT} adcseq_st_t;

  typedef struct packed {
    adcseq_st_t st;
    logic start;
    logic power;
    logic align;
    logic [2:0] div;
    logic [1:0] refs;
    logic [2:0] src;
    logic [4:0] chan;
    logic gie;
    logic cie;
    logic flag;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] mask;
    logic [RES_W-1:0] result;
    logic [3:0] cnt;
    logic done;
    logic [DATA_W-1:0] rdata;
  } adcseq_state_t;

  adcseq_state_t s;
  adcseq_state_t next_s;
  logic tick;
  logic busy;
  logic div_clear;
  logic wr_a;
  logic start_fall;
  logic [RES_W-1:0] decided;
  logic [DATA_W-1:0] res_hi;
  logic [DATA_W-1:0] res_lo;

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock

  assign busy = (s.st == ST_SAMPLE) || (s.st == ST_CONVERT);
  assign div_clear = !busy;

  adcseq_clkdiv u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .clear(div_clear),
    .conv_clock_div_sel(s.div),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result byte alignment

  always_comb begin
    if (s.align) begin
      res_hi = {4'h0, s.result[11:8]};
      res_lo = s.result[7:0];
    end else begin
      res_hi = s.result[11:4];
      res_lo = {s.result[3:0], 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign wr_a = bus.we && (bus.addr == ADDR_CTRL_A);
  assign start_fall = wr_a && s.start && !bus.wdata[CA_START];
  // Keep the trial bit only if input is at or above the trial code
  assign decided = cmp_above ? s.sar : (s.sar & ~s.mask);

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rdata = '0;
    // Register writes
    if (wr_a) begin
      next_s.start = bus.wdata[CA_START];
      next_s.power = bus.wdata[CA_POWER];
      next_s.align = bus.wdata[CA_ALIGN];
    end
    if (bus.we && (bus.addr == ADDR_CTRL_B)) begin
      next_s.div = bus.wdata[CB_DIV_LSB +: 3];
      next_s.refs = bus.wdata[CB_REF_LSB +: 2];
    end
    if (bus.we && (bus.addr == ADDR_CTRL_C)) begin
      next_s.chan = bus.wdata[CC_CHAN_LSB +: 5];
      next_s.src = bus.wdata[CC_SRC_LSB +: 3];
    end
    if (bus.we && (bus.addr == ADDR_IRQ)) begin
      next_s.gie = bus.wdata[IRQ_GIE];
      next_s.cie = bus.wdata[IRQ_CIE];
      // Writing zero clears; writing one leaves it
      next_s.flag = s.flag & bus.wdata[IRQ_FLAG];
    end
    // Sequencer
    case (s.st)
      ST_IDLE, ST_HOLD: begin
        if (start_fall && next_s.power) begin
          next_s.st = ST_SAMPLE;
          next_s.cnt = 4'h0;
        end else begin
          next_s.st = ST_IDLE;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          if (s.cnt == SAMPLE_CLKS - 4'h1) begin
            next_s.st = ST_CONVERT;
            next_s.cnt = 4'h0;
            next_s.sar = SAR_MSB;
            next_s.mask = SAR_MSB;
          end else begin
            next_s.cnt = 4'(s.cnt + 4'h1);
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          next_s.mask = s.mask >> 1;
          next_s.sar = decided | (s.mask >> 1);
          next_s.cnt = 4'(s.cnt + 4'h1);
          if (s.cnt == CONV_CLKS - 4'h1) begin
            next_s.st = ST_IDLE;
            next_s.result = decided;
            next_s.done = 1'b1;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // Start held high keeps the converter in reset
    if (next_s.start) begin
      next_s.st = ST_HOLD;
    end
    // Power off aborts any conversion
    if (!next_s.power) begin
      next_s.st = ST_IDLE;
    end
    // Completion wins over a clear in the same cycle
    if (next_s.done) begin
      next_s.flag = 1'b1;
    end
    // Registered read data, valid only the cycle after the strobe
    if (bus.re) begin
      case (bus.addr)
        ADDR_CTRL_A: next_s.rdata = {s.start, busy, s.power, s.align, 4'h0};
        ADDR_CTRL_B: next_s.rdata = {2'h0, s.refs, 1'b0, s.div};
        ADDR_CTRL_C: next_s.rdata = {s.src, s.chan};
        ADDR_RES_HI: next_s.rdata = res_hi;
        ADDR_RES_LO: next_s.rdata = res_lo;
        ADDR_IRQ: next_s.rdata = {5'h00, s.flag, s.cie, s.gie};
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.div <= RST_DIV;
      s.refs <= RST_REF;
      s.src <= RST_SRC;
      s.chan <= RST_CHAN;
      s.result <= RST_RESULT;
    end else if (ce) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    analog.power_en = s.power;
    analog.sample_en = (s.st == ST_SAMPLE);
    analog.ref_from_supply = (s.refs == REF_SUPPLY);
    analog.bandgap_sel = (s.src == SRC_BANDGAP) && (s.chan >= CHAN_NONE_MIN);
    analog.ext_channel_en = (s.chan < CHAN_NONE_MIN) && ((s.src == SRC_EXT) || (s.src >= SRC_EXT_ALT_MIN));
    analog.channel_sel = s.chan;
    analog.internal_source_sel = s.src;
    analog.dac_code = (s.st == ST_CONVERT) ? s.sar : '0;
  end

  assign rdata = s.rdata;
  assign conv_busy_flag = busy;
  assign conv_irq_req = s.flag && s.cie && s.gie;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [4:0] tick_seen;

  // Converter periods elapsed since the conversion began
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_seen <= 5'h00;
    end else if (ce) begin
      if (!busy) begin
        tick_seen <= 5'h00;
      end else if (tick) begin
        tick_seen <= 5'(tick_seen + 5'h01);
      end
    end
  end

  logic [RES_W-1:0] dec_log;

  // Comparator decisions, first one in the top bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dec_log <= RST_RESULT;
    end else if (ce && tick && (s.st == ST_CONVERT)) begin
      dec_log <= {dec_log[RES_W-2:0], cmp_above};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_sample_length: assert property (ce && $fell(analog.sample_en) && busy |-> tick_seen == 5'(SAMPLE_CLKS))
    else $error("sample phase length wrong");
  a_total_length: assert property ($rose(s.done) |-> tick_seen == TOTAL_CLKS)
    else $error("conversion length wrong");
  a_start_begins: assert property (ce && start_fall && bus.wdata[CA_POWER] |=> busy ##0 analog.sample_en)
    else $error("falling start did not begin conversion");
  a_start_holds: assert property (s.start |-> !busy)
    else $error("converter not held while start high");
  a_power_down: assert property (!analog.power_en |-> !busy && !conv_busy_flag)
    else $error("conversion ran while powered down");
  a_done_flags: assert property ($rose(s.done) |-> !conv_busy_flag && s.flag && $past(busy))
    else $error("completion did not clear busy or set flag");
  a_flag_sticky: assert property (s.flag && !(ce && bus.we && bus.addr == ADDR_IRQ && !bus.wdata[IRQ_FLAG]) |=> s.flag)
    else $error("request flag lost");
  a_align_high: assert property (ce && bus.re && bus.addr == ADDR_RES_HI && s.align |=> rdata[7:4] == 4'h0)
    else $error("right aligned high byte not zero padded");
  a_bandgap_input: assert property (analog.bandgap_sel == (s.src == SRC_BANDGAP && s.chan[4:3] == 2'b11)
    && !(analog.bandgap_sel && analog.ext_channel_en))
    else $error("bandgap selected with external channel");
  a_busy_stable: assert property (ce && busy && !tick && !wr_a && s.power && !s.start |=> busy)
    else $error("busy dropped without a converter clock");

  // Datapath and register checks
  a_result_kept: assert property (!s.done |-> $stable(s.result))
    else $error("result changed without a completion");
  a_result_decisions: assert property ($rose(s.done) |-> s.result == dec_log)
    else $error("result differs from comparator decisions");
  a_trial_bit: assert property (s.st == ST_CONVERT
    |-> $onehot(s.mask) && (analog.dac_code & s.mask) == s.mask)
    else $error("trial bit missing from converter code");
  a_sample_busy: assert property (analog.sample_en |-> conv_busy_flag)
    else $error("sampling while not busy");
  a_power_quiet: assert property (!analog.power_en |-> analog.dac_code == '0 && !analog.sample_en)
    else $error("analog active while powered down");
  a_flag_clear: assert property (ce && bus.we && bus.addr == ADDR_IRQ
    && !bus.wdata[IRQ_FLAG] && !next_s.done |=> !s.flag)
    else $error("request flag not cleared by software");
  a_rdata_idle: assert property (ce && !bus.re |=> rdata == '0)
    else $error("read data not zero outside a read");

  c_full_conversion: cover property ($rose(s.done));
  c_full_scale: cover property ($rose(s.done) && s.result == FULL_SCALE);
  c_power_abort: cover property (busy ##1 !analog.power_en);
  c_restart_abort: cover property (analog.sample_en ##1 s.start);
  c_right_align: cover property ($rose(s.done) && s.align);

endmodule : adcseq_top

// >>> bench/adcseq_top_bench.sv
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ps
module adcseq_top_bench;
  import adcseq_pkg::*;
  logic clk_sys;
  logic rst;
  logic ce;
  adcseq_bus_req_t bus;
  logic [DATA_W-1:0] rdata;
  logic cmp_above;
  adcseq_analog_t analog;
  logic conv_busy_flag;
  logic conv_irq_req;
  logic [RES_W-1:0] vin;
  logic [RES_W-1:0] last_r;
  logic [31:0] seed;
  logic [7:0] d;
  logic [7:0] lo;
  logic [2:0] div;
  logic al;
  logic en;
  int n;
  int miscompares;
  int comparisons;

  adcseq_top u_adcseq_top (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .bus(bus),
    .rdata(rdata),
    .cmp_above(cmp_above),
    .analog(analog),
    .conv_busy_flag(conv_busy_flag),
    .conv_irq_req(conv_irq_req)
  );

  // Ideal comparator against the bench's input level
  assign cmp_above = (vin >= analog.dac_code);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [15:0] pair_of(input logic [11:0] r, input logic align);
    return align ? {4'h0, r} : {r, 4'h0};
  endfunction : pair_of

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk_sys);
    bus.we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_sys);
    bus.re <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // Start pulse, then count cycles with busy high
  task automatic convert(input logic [2:0] dv, input logic align, input logic [11:0] level);
    vin = level;
    wr(ADDR_CTRL_B, {5'h00, dv});
    wr(ADDR_CTRL_A, {3'b101, align, 4'h0});
    wr(ADDR_CTRL_A, {3'b001, align, 4'h0});
    n = 0;
    #1;
    while (conv_busy_flag === 1'b1 && n < 5000) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
  endtask : convert

  task automatic results();
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    #500000;
    miscompares++;
    results();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bus = '0;
    vin = 12'h000;
    seed = 32'h0000_0051;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rd(a[ADDR_W-1:0], d);
      chk("reset_read", {8'h00, d}, 16'h0000);
    end
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_CTRL_B, {2'b00, r[1:0], 4'h0});
      #1;
      chk("ref_from_supply", {15'h0, analog.ref_from_supply}, {15'h0, r == 1});
    end
    seed = xorshift(seed);
    wr(ADDR_CTRL_C, {3'b000, 2'b11, seed[2:0]});
    wr(ADDR_CTRL_C, {3'b001, 2'b11, seed[2:0]});
    #1;
    chk("bandgap", {14'h0, analog.bandgap_sel, analog.ext_channel_en}, 16'h0002);
    wr(ADDR_CTRL_C, {3'b000, 5'h17});
    #1;
    chk("ext_channel", {14'h0, analog.bandgap_sel, analog.ext_channel_en}, 16'h0001);
    wr(ADDR_CTRL_A, 8'h20);
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 14; i++) begin
      seed = xorshift(seed);
      div = {1'b0, seed[1:0]};
      al = seed[4];
      en = seed[7];
      last_r = (i == 0) ? 12'h000 : (i == 1) ? FULL_SCALE : seed[27:16];
      wr(ADDR_IRQ, {6'h00, en, en});
      convert(div, al, last_r);
      chk("busy_cycles", n[15:0], 16'(16 * (1 << div) + 1));
      rd(ADDR_RES_HI, d);
      rd(ADDR_RES_LO, lo);
      chk("result", {d, lo}, pair_of(last_r, al));
      rd(ADDR_IRQ, d);
      chk("irq_reg", {8'h00, d}, {13'h0, 1'b1, en, en});
      chk("irq_req", {15'h0, conv_irq_req}, {15'h0, en});
      wr(ADDR_IRQ, {6'h00, en, en});
      #1;
      chk("irq_cleared", {15'h0, conv_irq_req}, 16'h0000);
    end
    vin = ~last_r;
    wr(ADDR_CTRL_B, 8'h02);
    wr(ADDR_CTRL_A, 8'hA0);
    wr(ADDR_CTRL_A, 8'h20);
    #1;
    chk("power_on", {15'h0, analog.power_en}, 16'h0001);
    rd(ADDR_CTRL_A, d);
    chk("busy_bit", {8'h00, d}, 16'h0060);
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys);
    ce <= 1'b1;
    #1;
    chk("ce_freeze", {15'h0, analog.sample_en}, 16'h0001);
    wr(ADDR_CTRL_A, 8'hA0);
    @(posedge clk_sys);
    #1;
    chk("hold_busy", {15'h0, conv_busy_flag}, 16'h0000);
    wr(ADDR_CTRL_A, 8'h20);
    wr(ADDR_CTRL_A, 8'h00);
    @(posedge clk_sys);
    #1;
    chk("power_off", {14'h0, analog.power_en, conv_busy_flag}, 16'h0000);
    wr(ADDR_CTRL_A, 8'h80);
    wr(ADDR_CTRL_A, 8'h00);
    #1;
    chk("no_power_start", {15'h0, conv_busy_flag}, 16'h0000);
    rd(ADDR_RES_HI, d);
    rd(ADDR_RES_LO, lo);
    chk("abort_result", {d, lo}, pair_of(last_r, 1'b0));
    results();
  end
endmodule : adcseq_top_bench
